// *** sfp_pkg.sv ***
// Constants for the serial flash SPI front end
package sfp_pkg;
  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int PAGE_COUNT = 1024;
  localparam int PAGE_IDX_W = 10;
  localparam int BYTE_OFF_W = 9;
  localparam int PAGE_BYTES_STD = 256;
  localparam int PAGE_BYTES_EXT = 264;
  localparam int SEC_BYTES = 128;
  localparam int SEC_OFF_W = 7;
  localparam int ADDR_BYTES = 3;
  localparam int OPCODE_W = 8;

  // ****************************************************************
  // Address field positions in the 24-bit address word
  // ****************************************************************
  localparam int STD_PAGE_LSB = 8;
  localparam int STD_BYTE_MSB = 7;
  localparam int EXT_PAGE_LSB = 9;
  localparam int EXT_BYTE_MSB = 8;

  // ****************************************************************
  // Opcodes handled inside the front end
  // ****************************************************************
  localparam logic [7:0] OP_ARRAY_READ = 8'h0B;
  localparam logic [7:0] OP_BUF_READ = 8'hD1;
  localparam logic [7:0] OP_BUF_WRITE = 8'h84;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SEC_READ = 8'h77;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [23:0] ADDR_RST = 24'h000000;

  typedef enum {
    SFP_IDLE,
    SFP_OPCODE,
    SFP_ADDR,
    SFP_DATA
  } sfp_phase_e;
endpackage : sfp_pkg

// *** sfp_spi_port.sv ***
// SPI slave front end of a page-erase serial flash with one page buffer
`timescale 1ns/1ps
module sfp_spi_port
  import sfp_pkg::*;
#(
  parameter int BUF_BYTES = PAGE_BYTES_EXT,
  // Arbitrary preload value, stands for the unique identifier
  parameter logic [SEC_BYTES*8-1:0] SEC_INIT = {SEC_BYTES{8'h5A}}
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic soOeN,
  input wire logic pageSize264,
  input wire logic coreBusy,
  output logic [OPCODE_W-1:0] opcode,
  output logic opValid,
  output logic opEnd,
  output logic [PAGE_IDX_W-1:0] pageIndex,
  output logic [BYTE_OFF_W-1:0] byteOffset,
  output logic memRdReq,
  input wire logic [7:0] memRdData,
  output logic progStrobe,
  output logic [7:0] progData,
  output logic [PAGE_IDX_W-1:0] progPage,
  output logic [BYTE_OFF_W-1:0] progOffset,
  output logic standby
);

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  logic sckPrev;
  logic csPrev;
  logic sckRise;
  logic sckFall;
  logic csFall;
  logic csRise;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sckPrev <= 1'b0;
      csPrev <= 1'b1;
    end else begin
      sckPrev <= sck;
      csPrev <= csN;
    end
  end

  // Idle level of the clock never matters, only its edges inside a frame
  assign sckRise = !csN && !csPrev && sck && !sckPrev;
  assign sckFall = !csN && !csPrev && !sck && sckPrev;
  assign csFall = csPrev && !csN;
  assign csRise = !csPrev && csN;

  // ****************************************************************
  // Bit and byte framing
  // ****************************************************************
  sfp_phase_e phase;
  logic [2:0] bitCnt;
  logic [6:0] shiftIn;
  logic [1:0] addrCnt;
  logic [15:0] addrHi;
  logic [7:0] rxByte;
  logic [23:0] addrWord;
  logic byteDone;
  logic isArrayRd;
  logic isBufRd;
  logic isSecRd;
  logic isRead;
  logic [BYTE_OFF_W-1:0] lastOff;

  assign rxByte = {shiftIn, si};
  assign byteDone = sckRise && (bitCnt == 3'h7);
  assign addrWord = {addrHi, rxByte};
  assign isArrayRd = (opcode == OP_ARRAY_READ);
  assign isBufRd = (opcode == OP_BUF_READ);
  assign isSecRd = (opcode == OP_SEC_READ);
  assign isRead = isArrayRd || isBufRd || isSecRd;
  assign lastOff = pageSize264 ? BYTE_OFF_W'(PAGE_BYTES_EXT - 1) :
                   BYTE_OFF_W'(PAGE_BYTES_STD - 1);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bitCnt <= 3'h0;
      shiftIn <= 7'h00;
    end else if (csFall) begin
      bitCnt <= 3'h0;
    end else if (sckRise) begin
      bitCnt <= bitCnt + 3'h1;
      shiftIn <= rxByte[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase <= SFP_IDLE;
    end else if (csRise) begin
      phase <= SFP_IDLE;
    end else if (csFall) begin
      phase <= SFP_OPCODE;
    end else if (byteDone) begin
      case (phase)
        SFP_OPCODE: phase <= SFP_ADDR;
        SFP_ADDR: begin
          if (addrCnt == 2'(ADDR_BYTES - 1)) begin
            phase <= SFP_DATA;
          end
        end
        SFP_DATA: phase <= SFP_DATA;
        default: phase <= SFP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      opcode <= BYTE_RST;
      addrCnt <= 2'h0;
      addrHi <= 16'h0000;
    end else if (csFall) begin
      addrCnt <= 2'h0;
    end else if (byteDone && phase == SFP_OPCODE) begin
      opcode <= rxByte;
    end else if (byteDone && phase == SFP_ADDR) begin
      addrCnt <= addrCnt + 2'h1;
      addrHi <= addrWord[15:0];
    end
  end

  // ****************************************************************
  // Address decode and sequential advance
  // ****************************************************************
  logic addrDone;
  logic advance;

  assign addrDone = byteDone && phase == SFP_ADDR && addrCnt == 2'(ADDR_BYTES - 1);
  assign advance = byteDone && phase == SFP_DATA;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pageIndex <= '0;
      byteOffset <= '0;
    end else if (addrDone) begin
      if (pageSize264) begin
        pageIndex <= addrWord[EXT_PAGE_LSB +: PAGE_IDX_W];
        byteOffset <= addrWord[EXT_BYTE_MSB:0];
      end else begin
        pageIndex <= addrWord[STD_PAGE_LSB +: PAGE_IDX_W];
        byteOffset <= {1'b0, addrWord[STD_BYTE_MSB:0]};
      end
    end else if (advance) begin
      if (byteOffset >= lastOff) begin
        byteOffset <= '0;
        // Array read rolls into the next page and wraps at the end
        if (isArrayRd) begin
          pageIndex <= pageIndex + PAGE_IDX_W'(1);
        end
      end else begin
        byteOffset <= byteOffset + BYTE_OFF_W'(1);
      end
    end
  end

  // Fetch strobe registered with the offset, high in the first cycle of the new offset
  logic fetch;
  logic rdPend;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fetch <= 1'b0;
      opValid <= 1'b0;
    end else begin
      fetch <= (addrDone || advance) && isRead;
      opValid <= addrDone;
    end
  end

  assign memRdReq = fetch && isArrayRd;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdPend <= 1'b0;
    end else begin
      rdPend <= memRdReq;
    end
  end

  // ****************************************************************
  // Page buffer and security area
  // ****************************************************************
  logic [7:0] bufMem [BUF_BYTES];
  logic bufWrite;
  logic [7:0] secByte;

  assign bufWrite = advance && opcode == OP_BUF_WRITE && byteOffset < BUF_BYTES;

  always_ff @(posedge clk) begin
    if (bufWrite) begin
      bufMem[byteOffset] <= rxByte;
    end
  end

  assign secByte = SEC_INIT[{byteOffset[SEC_OFF_W-1:0], 3'h0} +: 8];

  // ****************************************************************
  // Direct program stream to the core
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      progStrobe <= 1'b0;
      progData <= BYTE_RST;
      progPage <= '0;
      progOffset <= '0;
    end else begin
      progStrobe <= advance && opcode == OP_PROGRAM;
      if (advance && opcode == OP_PROGRAM) begin
        progData <= rxByte;
        progPage <= pageIndex;
        progOffset <= byteOffset;
      end
    end
  end

  // ****************************************************************
  // Output shifter
  // ****************************************************************
  logic [7:0] txByte;
  logic [7:0] txShift;
  logic loadPend;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txByte <= BYTE_RST;
    end else if (rdPend) begin
      txByte <= memRdData;
    end else if (fetch && isBufRd) begin
      txByte <= (byteOffset < BUF_BYTES) ? bufMem[byteOffset] : BYTE_RST;
    end else if (fetch && isSecRd) begin
      txByte <= secByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      so <= 1'b0;
      txShift <= BYTE_RST;
      loadPend <= 1'b0;
    end else if (csFall) begin
      loadPend <= 1'b0;
    end else begin
      if (addrDone || advance) begin
        loadPend <= 1'b1;
      end else if (sckFall) begin
        loadPend <= 1'b0;
      end
      if (sckFall) begin
        if (loadPend) begin
          so <= txByte[7];
          txShift <= {txByte[6:0], 1'b0};
        end else begin
          so <= txShift[7];
          txShift <= {txShift[6:0], 1'b0};
        end
      end
    end
  end

  // Driven only inside a frame, in the data phase of a read
  assign soOeN = !(!csN && phase == SFP_DATA && isRead);

  // ****************************************************************
  // Operation end and standby
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      opEnd <= 1'b0;
    end else begin
      opEnd <= csRise;
    end
  end

  // Busy core holds the device active after deselect
  assign standby = csN && !coreBusy;

endmodule : sfp_spi_port

// *** sfp_host_model.sv ***
// Host SPI controller model driving select, serial clock and serial input
`timescale 1ns/1ps
module sfp_host_model (
  input wire logic clk,
  input wire logic so,
  input wire logic soOeN,
  output logic csN,
  output logic sck,
  output logic si
);
  initial {csN, sck, si} = 3'b100;
  task automatic open(input logic m3);
    @(negedge clk);
    sck = m3;
    repeat (3) @(negedge clk);
    csN = 1'b0;
    repeat (3) @(negedge clk);
  endtask : open
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      repeat (3) @(negedge clk);
      // Released line reads inverted, so a missing enable shows up as bad data
      rx[i] = soOeN ? ~so : so;
      sck = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask : xfer
  task automatic close(input logic m3);
    sck = m3;
    repeat (3) @(negedge clk);
    csN = 1'b1;
    si = ~si;
    repeat (4) @(negedge clk);
  endtask : close
  // Clock and data wiggle while deselected
  task automatic noise(input int n);
    repeat (n) begin
      @(negedge clk);
      sck = ~sck;
      si = ~si ^ sck;
    end
  endtask : noise
endmodule : sfp_host_model

// *** sfp_spi_port_monitor.sv ***
// Assertion checker for the serial flash SPI front end
`timescale 1ns/1ps
module sfp_spi_port_monitor
  import sfp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic csN,
  input wire logic sck,
  input wire logic so,
  input wire logic soOeN,
  input wire logic pageSize264,
  input wire logic coreBusy,
  input wire logic [OPCODE_W-1:0] opcode,
  input wire logic opValid,
  input wire logic opEnd,
  input wire logic [BYTE_OFF_W-1:0] byteOffset,
  input wire logic progStrobe,
  input wire logic standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_hiz; csN |-> soOeN; endproperty
  a_hiz: assert property (p_hiz) else $error("so driven while deselected");
  property p_stby; standby == (csN && !coreBusy); endproperty
  a_stby: assert property (p_stby) else $error("standby wrong");
  property p_busy; csN && coreBusy |-> !standby; endproperty
  a_busy: assert property (p_busy) else $error("standby while busy");
  property p_ign; csN [*3] |-> !opValid && !progStrobe; endproperty
  a_ign: assert property (p_ign) else $error("activity while deselected");
  property p_end; $rose(csN) |-> ##[1:2] opEnd; endproperty
  a_end: assert property (p_end) else $error("no frame end pulse");
  property p_fall; !soOeN && $changed(so) |-> $past(sck, 2) && !$past(sck); endproperty
  a_fall: assert property (p_fall) else $error("so changed off falling edge");
  property p_addr; opValid |-> !csN ##1 !opValid; endproperty
  a_addr: assert property (p_addr) else $error("address pulse wrong");
  property p_std; opValid && !pageSize264 |-> byteOffset[8] == 1'b0; endproperty
  a_std: assert property (p_std) else $error("offset too wide");
  property p_ext; opValid && pageSize264 |-> byteOffset < 9'h108; endproperty
  a_ext: assert property (p_ext) else $error("offset past page");
  property p_prog; progStrobe |-> opcode == OP_PROGRAM; endproperty
  a_prog: assert property (p_prog) else $error("program strobe without program");
endmodule : sfp_spi_port_monitor
bind sfp_spi_port sfp_spi_port_monitor u_mon (.clk, .reset_n, .csN, .sck, .so, .soOeN,
  .pageSize264, .coreBusy, .opcode, .opValid, .opEnd, .byteOffset, .progStrobe, .standby);

// *** sfp_spi_port_tb_top.sv ***
// Self-checking testbench for the serial flash SPI front end
`timescale 1ns/1ps
module sfp_spi_port_tb_top;
  import sfp_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, pageSize264 = 1'b0, coreBusy = 1'b0;
  logic [7:0] memRdData = 8'h00;
  logic csN, sck, si, so, soOeN, opValid, opEnd, memRdReq, progStrobe, standby;
  logic [7:0] opcode, progData;
  logic [9:0] pageIndex, progPage;
  logic [8:0] byteOffset, progOffset;
  int failures = 0;
  int tests_run = 0;
  int opEnds = 0;
  int addrValids = 0;
  logic [31:0] seed = 32'h00000031;
  logic [7:0] rxq[$];
  logic [26:0] pq[$];
  logic [7:0] ops[4] = '{OP_ARRAY_READ, OP_PROGRAM, OP_BUF_WRITE, OP_SEC_READ};
  always #10 clk = ~clk;
  sfp_spi_port #(.SEC_INIT({SEC_BYTES{8'hC3}})) uut (.clk, .reset_n, .csN, .sck, .si,
    .so, .soOeN, .pageSize264, .coreBusy, .opcode, .opValid, .opEnd, .pageIndex,
    .byteOffset, .memRdReq, .memRdData, .progStrobe, .progData, .progPage, .progOffset,
    .standby);
  sfp_host_model host (.clk, .so, .soOeN, .csN, .sck, .si);
  always @(posedge clk) begin
    if (memRdReq) memRdData <= mem_byte(pageIndex, byteOffset);
    if (progStrobe) pq.push_back({progPage, progOffset, progData});
    if (opEnd) opEnds++;
    if (opValid) addrValids++;
  end
  function automatic logic [7:0] mem_byte(input logic [9:0] p, input logic [8:0] o);
    return p[7:0] ^ o[7:0] ^ {5'h00, o[8], p[9:8]};
  endfunction : mem_byte
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [26:0] got, input logic [26:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic frame(input logic m3, input logic [7:0] op, input logic [23:0] a,
                       input int n, input logic [7:0] tx[$]);
    logic [7:0] r;
    rxq.delete();
    opEnds = 0;
    addrValids = 0;
    host.open(m3);
    host.xfer(op, r);
    for (int i = 2; i >= 0; i--) host.xfer(a[i*8+:8], r);
    for (int i = 0; i < n; i++) begin
      host.xfer(tx[i], r);
      rxq.push_back(r);
    end
    host.close(m3);
    check(27'(opcode), 27'(op));
    check(27'(addrValids), 27'h1);
    check(27'(opEnds), 27'h1);
  endtask : frame
  task automatic run(input logic m3, input logic ext, input logic [7:0] op,
                     input logic [9:0] p, input logic [8:0] o, input int n);
    logic [7:0] tx[$];
    logic [23:0] a;
    logic [7:0] e;
    pageSize264 = ext;
    a = ext ? {5'h00, p, o} : {6'h00, p, o[7:0]};
    pq.delete();
    repeat (n) tx.push_back(8'(rnd()));
    frame(m3, op, a, n, tx);
    if (op == OP_BUF_WRITE) frame(m3, OP_BUF_READ, a, n, tx);
    for (int i = 0; i < n; i++) begin
      e = (op == OP_ARRAY_READ) ? mem_byte(p, o) : (op == OP_SEC_READ) ? 8'hC3 : tx[i];
      if (op == OP_PROGRAM) check(pq[i], {p, o, e});
      else check(27'(rxq[i]), 27'(e));
      o = (o == (ext ? 9'h107 : 9'h0FF)) ? 9'h000 : o + 9'h001;
      if (o == 9'h000 && op == OP_ARRAY_READ) p = p + 10'h001;
    end
    $display("Test opcode %h done", op);
  endtask : run
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  initial begin
    #800000;
    failures++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    run(1'b0, 1'b0, OP_ARRAY_READ, 10'h3FF, 9'h0FE, 4);
    run(1'b1, 1'b1, OP_ARRAY_READ, 10'h3FF, 9'h106, 4);
    run(1'b1, 1'b0, OP_PROGRAM, 10'h155, 9'h0FF, 3);
    run(1'b0, 1'b1, OP_BUF_WRITE, 10'h000, 9'h105, 4);
    run(1'b1, 1'b0, OP_SEC_READ, 10'h000, 9'h07E, 3);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      run(r[0], r[1], ops[r[4:3]], r[31:22], 9'(r[20:12] % (r[1] ? 264 : 256)),
          1 + int'(r[6:5]));
    end
    pq.delete();
    host.noise(24);
    check(27'(pq.size()), 27'h0);
    coreBusy = 1'b1;
    @(negedge clk);
    check(27'(standby), 27'h0);
    coreBusy = 1'b0;
    @(negedge clk);
    check(27'(standby), 27'h1);
    check(27'(soOeN), 27'h1);
    $display("Test deselect done");
    summarize();
  end
endmodule : sfp_spi_port_tb_top
